/* File: logic/dda_pkg.sv */
package dda_pkg;
  localparam int DDA_WORD_W = 24;
  localparam int DDA_ACC_W = 48;
  localparam int DDA_EXT_W = 8;
  localparam int DDA_FULL_W = 56;
  localparam int DDA_PROD_W = 96;
  localparam int DDA_CLK_PER_ICYC = 2;
  localparam int DDA_DP_ICYC = 6;
  localparam logic [3:0] DDA_DP_CLKS = 4'(DDA_DP_ICYC * DDA_CLK_PER_ICYC);
  localparam logic [23:0] DDA_POS_MAX = 24'h7fffff;
  localparam logic [23:0] DDA_NEG_MAX = 24'h800000;
  localparam logic [55:0] DDA_ACC_RST = 56'h00000000000000;
  localparam logic [23:0] DDA_IN_RST = 24'h000000;

  // Register selectors on the data buses
  typedef enum logic [3:0] {
    DDA_R_X0 = 4'h0,
    DDA_R_X1 = 4'h1,
    DDA_R_Y0 = 4'h2,
    DDA_R_Y1 = 4'h3,
    DDA_R_A0 = 4'h4,
    DDA_R_A1 = 4'h5,
    DDA_R_A2 = 4'h6,
    DDA_R_B0 = 4'h7,
    DDA_R_B1 = 4'h8,
    DDA_R_B2 = 4'h9,
    DDA_R_A = 4'ha,
    DDA_R_B = 4'hb
  } dda_reg_t;

  typedef enum logic [2:0] {
    DDA_OP_NOP = 3'h0,
    DDA_OP_MAC = 3'h1,
    DDA_OP_MPY = 3'h2,
    DDA_OP_ADD = 3'h3,
    DDA_OP_SUB = 3'h4,
    DDA_OP_DPMUL = 3'h5
  } dda_op_t;

  typedef enum logic [1:0] {
    DDA_SC_NONE = 2'h0,
    DDA_SC_DOWN = 2'h1,
    DDA_SC_UP = 2'h2
  } dda_scale_t;
endpackage

/* File: logic/dda_limiter.sv */
`timescale 1ns/1ns
module dda_limiter
  import dda_pkg::*;
(
  // Accumulator in
  input wire logic [55:0] acc,
  input wire logic [1:0] scale,
  input wire logic dbl,
  // Shifted and limited out
  output logic [47:0] dout,
  output logic ovf
);
  wire logic [56:0] sext = {acc[55], acc};
  wire logic [56:0] shl = {acc, 1'b0};
  wire logic [56:0] shr = {acc[55], acc[55], acc[55:1]};
  wire logic [56:0] sh = (scale == DDA_SC_UP) ? shl :
                         (scale == DDA_SC_DOWN) ? shr : sext;
  // Fit check: bits above the destination must all equal its sign bit
  wire logic [9:0] top48 = sh[56:47];
  wire logic [9:0] top24 = sh[56:47];
  wire logic fit48 = (top48 == '0) || (top48 == '1);
  wire logic fit24 = (top24 == '0) || (top24 == '1);
  wire logic neg = sh[56];
  wire logic [47:0] sat48 = neg ? {DDA_NEG_MAX, 24'h000000} :
                                  {DDA_POS_MAX, 24'hffffff};
  wire logic [23:0] sat24 = neg ? DDA_NEG_MAX : DDA_POS_MAX;
  assign ovf = dbl ? !fit48 : !fit24;
  // Single word takes the upper accumulator half, as fractions align at MSB
  wire logic fit_hi = (sh[56:47] == '0) || (sh[56:47] == '1);
  assign dout = dbl ? (fit48 ? sh[47:0] : sat48) :
                (fit_hi ? {sh[47:24], 24'h000000} :
                 {sat24, 24'h000000});
endmodule

/* File: logic/dda_alu.sv */
// Contract
// - Four 24-bit operand input registers
// - Two 48-bit accumulators with 8-bit extensions
// - Operands are fractional twos complement
// - 24x24 multiply-accumulate in two clocks
// - 56-bit add and subtract in two clocks
// - Registers reachable from both buses, 24/48
// - Output shifter passes, shifts left or right
// - Shifter gives 24-bit result plus overflow
// - Overflow saturates to extreme, sets error flag
// - 48x48 multiply, 96-bit product, six cycles
`timescale 1ns/1ns
module dda_alu
  import dda_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Operation issue
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic op_src_y,
  input wire logic op_dst_b,
  input wire logic [1:0] scale_mode,
  // Bus writes into the unit
  input wire logic x_wr,
  input wire logic [3:0] x_wr_sel,
  input wire logic [23:0] x_operand_bus_in,
  input wire logic y_wr,
  input wire logic [3:0] y_wr_sel,
  input wire logic [23:0] y_operand_bus_in,
  // Bus reads out of the unit
  input wire logic x_rd,
  input wire logic [3:0] x_rd_sel,
  input wire logic y_rd,
  input wire logic [3:0] y_rd_sel,
  input wire logic err_clr,
  output logic [23:0] x_operand_bus_out,
  output logic [23:0] y_operand_bus_out,
  output logic rd_valid,
  output logic limit_err,
  // Status
  output logic busy,
  output logic done,
  output logic [95:0] dp_product
);
  logic [23:0] in_reg [4];
  logic [55:0] acc_reg [2];
  logic phase_reg;
  logic [3:0] dp_cnt_reg;
  logic [2:0] op_reg;
  logic src_reg, dst_reg;
  logic [55:0] res_reg;

  typedef enum logic [1:0] {
    DDA_ST_IDLE = 2'h0,
    DDA_ST_EXEC = 2'h1,
    DDA_ST_DP = 2'h2
  } dda_state_t;
  dda_state_t st_reg;

  // Operand pairs: x0*y0 from the X side, x1*y1 from the Y side
  wire logic signed [23:0] opa = src_reg ? in_reg[1] : in_reg[0];
  wire logic signed [23:0] opb = src_reg ? in_reg[3] : in_reg[2];
  // Fractional product: doubled to drop the redundant sign bit
  wire logic signed [47:0] prod_raw = opa * opb;
  wire logic [55:0] prod_f = {{7{prod_raw[47]}}, prod_raw, 1'b0};
  wire logic [55:0] acc_d = acc_reg[dst_reg];
  wire logic [55:0] acc_o = acc_reg[!dst_reg];
  wire logic [55:0] mac_r = acc_d + prod_f;
  wire logic [55:0] add_r = acc_d + acc_o;
  wire logic [55:0] sub_r = acc_d - acc_o;
  wire logic [55:0] alu_r = (op_reg == DDA_OP_MAC) ? mac_r :
                            (op_reg == DDA_OP_MPY) ? prod_f :
                            (op_reg == DDA_OP_ADD) ? add_r :
                            (op_reg == DDA_OP_SUB) ? sub_r : acc_d;
  // Double precision: one combinational 48x48 multiply, held for six
  // instruction cycles so it fits the same slow timing budget.
  wire logic signed [47:0] dpa = {in_reg[1], in_reg[0]};
  wire logic signed [47:0] dpb = {in_reg[3], in_reg[2]};
  wire logic signed [95:0] dp_raw = dpa * dpb;
  wire logic [95:0] dp_frac = {dp_raw[94:0], 1'b0};

  // Output shifter/limiters, one per bus
  wire logic x_dbl = (x_rd_sel == DDA_R_A) || (x_rd_sel == DDA_R_B);
  wire logic y_dbl = (y_rd_sel == DDA_R_A) || (y_rd_sel == DDA_R_B);
  wire logic x_acc_b = (x_rd_sel == DDA_R_B) || (x_rd_sel == DDA_R_B1);
  wire logic y_acc_b = (y_rd_sel == DDA_R_B) || (y_rd_sel == DDA_R_B1);
  wire logic [47:0] x_lim, y_lim;
  wire logic x_ovf, y_ovf;
  dda_limiter u_lim_x (
    .acc(acc_reg[x_acc_b]),
    .scale(scale_mode),
    .dbl(x_dbl),
    .dout(x_lim),
    .ovf(x_ovf)
  );
  dda_limiter u_lim_y (
    .acc(acc_reg[y_acc_b]),
    .scale(scale_mode),
    .dbl(y_dbl),
    .dout(y_lim),
    .ovf(y_ovf)
  );
  wire logic x_lim_use = (x_rd_sel == DDA_R_A1) || (x_rd_sel == DDA_R_B1);
  wire logic y_lim_use = (y_rd_sel == DDA_R_A1) || (y_rd_sel == DDA_R_B1);

  // Registers passed in, so the read mux follows every register change
  wire logic [95:0] in_all = {in_reg[3], in_reg[2], in_reg[1], in_reg[0]};
  wire logic [111:0] acc_all = {acc_reg[1], acc_reg[0]};
  function automatic logic [23:0] raw_rd(input logic [3:0] s,
      input logic [47:0] lim, input logic [95:0] ir, input logic [111:0] ac);
    case (s)
      DDA_R_X0: return ir[23:0];
      DDA_R_X1: return ir[47:24];
      DDA_R_Y0: return ir[71:48];
      DDA_R_Y1: return ir[95:72];
      DDA_R_A0: return ac[23:0];
      DDA_R_A1: return lim[47:24];
      DDA_R_A2: return {{16{ac[55]}}, ac[55:48]};
      DDA_R_B0: return ac[79:56];
      DDA_R_B1: return lim[47:24];
      DDA_R_B2: return {{16{ac[111]}}, ac[111:104]};
      default: return 24'h000000;
    endcase
  endfunction

  // Long read: X bus carries the high word, Y bus the low word
  wire logic long_rd = x_rd && x_dbl;
  wire logic [23:0] x_rd_val = long_rd ? x_lim[47:24] :
                               raw_rd(x_rd_sel, x_lim, in_all, acc_all);
  wire logic [23:0] y_rd_val = long_rd ? x_lim[23:0] :
                               raw_rd(y_rd_sel, y_lim, in_all, acc_all);
  wire logic err_set = (long_rd && x_ovf) ||
                       (x_rd && x_lim_use && x_ovf) ||
                       (!long_rd && y_rd && y_lim_use && y_ovf);
  wire logic start = op_valid && (st_reg == DDA_ST_IDLE);

  // Operand input registers, one word per write, X bus wins over Y
  for (genvar i = 0; i < 4; i++) begin : g_in
    wire logic xw = x_wr && (x_wr_sel == 4'(i));
    wire logic yw = y_wr && (y_wr_sel == 4'(i));
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        in_reg[i] <= DDA_IN_RST;
      end else if (xw) begin
        in_reg[i] <= x_operand_bus_in;
      end else if (yw) begin
        in_reg[i] <= y_operand_bus_in;
      end
    end
  end

  // Accumulators: bus writes in any state unless a result lands, results at end of cycle
  for (genvar k = 0; k < 2; k++) begin : g_acc
    wire logic [3:0] s0 = k ? DDA_R_B0 : DDA_R_A0;
    wire logic [3:0] s1 = k ? DDA_R_B1 : DDA_R_A1;
    wire logic [3:0] s2 = k ? DDA_R_B2 : DDA_R_A2;
    wire logic [3:0] sl = k ? DDA_R_B : DDA_R_A;
    wire logic wr_long = x_wr && (x_wr_sel == sl);
    wire logic res_wr = (st_reg == DDA_ST_EXEC) && phase_reg &&
                        (dst_reg == 1'(k));
    logic [55:0] nxt;
    always_comb begin
      nxt = acc_reg[k];
      if (wr_long) begin
        nxt = {{8{x_operand_bus_in[23]}}, x_operand_bus_in,
               y_operand_bus_in};
      end else begin
        if (x_wr && x_wr_sel == s1) begin
          nxt = {{8{x_operand_bus_in[23]}}, x_operand_bus_in, 24'h000000};
        end
        if (y_wr && y_wr_sel == s1) begin
          nxt = {{8{y_operand_bus_in[23]}}, y_operand_bus_in, 24'h000000};
        end
        if (x_wr && x_wr_sel == s0) nxt[23:0] = x_operand_bus_in;
        if (y_wr && y_wr_sel == s0) nxt[23:0] = y_operand_bus_in;
        if (x_wr && x_wr_sel == s2) nxt[55:48] = x_operand_bus_in[7:0];
        if (y_wr && y_wr_sel == s2) nxt[55:48] = y_operand_bus_in[7:0];
      end
    end
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        acc_reg[k] <= DDA_ACC_RST;
      end else if (res_wr) begin
        acc_reg[k] <= res_reg;
      end else begin
        acc_reg[k] <= nxt;
      end
    end
  end

  // Issue sequencer: phase 0 computes, phase 1 writes back
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= DDA_ST_IDLE;
      phase_reg <= 1'b0;
      dp_cnt_reg <= 4'h0;
      op_reg <= DDA_OP_NOP;
      src_reg <= 1'b0;
      dst_reg <= 1'b0;
      res_reg <= DDA_ACC_RST;
      done <= 1'b0;
      busy <= 1'b0;
      dp_product <= 96'h0;
    end else begin
      done <= 1'b0;
      case (st_reg)
        DDA_ST_IDLE: begin
          if (start) begin
            op_reg <= op_code;
            src_reg <= op_src_y;
            dst_reg <= op_dst_b;
            phase_reg <= 1'b0;
            busy <= 1'b1;
            dp_cnt_reg <= 4'h1;
            st_reg <= (op_code == DDA_OP_DPMUL) ? DDA_ST_DP : DDA_ST_EXEC;
          end
        end
        DDA_ST_EXEC: begin
          phase_reg <= !phase_reg;
          res_reg <= alu_r;
          if (phase_reg) begin
            done <= 1'b1;
            busy <= 1'b0;
            st_reg <= DDA_ST_IDLE;
          end
        end
        DDA_ST_DP: begin
          dp_cnt_reg <= dp_cnt_reg + 4'h1;
          if (dp_cnt_reg == DDA_DP_CLKS) begin
            dp_product <= dp_frac;
            done <= 1'b1;
            busy <= 1'b0;
            st_reg <= DDA_ST_IDLE;
          end
        end
        default: st_reg <= DDA_ST_IDLE;
      endcase
    end
  end

  // Read port registers and sticky limit error
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      x_operand_bus_out <= 24'h000000;
      y_operand_bus_out <= 24'h000000;
      rd_valid <= 1'b0;
      limit_err <= 1'b0;
    end else begin
      rd_valid <= x_rd || y_rd;
      if (x_rd) x_operand_bus_out <= x_rd_val;
      if (y_rd || long_rd) y_operand_bus_out <= y_rd_val;
      if (err_set) begin
        limit_err <= 1'b1;
      end else if (err_clr) begin
        limit_err <= 1'b0;
      end
    end
  end

  property p_mac_two_clk;
    @(posedge clk_sys) disable iff (srst)
    (start && op_code != DDA_OP_DPMUL) |=> ##2 done;
  endproperty
  a_mac_two_clk: assert property (p_mac_two_clk)
    else $error("op not done in two clocks");

  sequence s_dp_start;
    start && op_code == DDA_OP_DPMUL;
  endsequence
  sequence s_dp_wait;
    (busy && !done) [*8] ##1 (busy && !done) ##1 (busy && !done)
      ##1 (busy && !done) ##1 (busy && !done) ##1 done;
  endsequence
  property p_dp_six;
    @(posedge clk_sys) disable iff (srst)
    s_dp_start |=> s_dp_wait;
  endproperty
  a_dp_six: assert property (p_dp_six)
    else $error("double multiply not done in twelve clocks");

  property p_mac_value;
    @(posedge clk_sys) disable iff (srst)
    (st_reg == DDA_ST_EXEC && phase_reg) |=>
      acc_reg[$past(dst_reg)] == $past(res_reg);
  endproperty
  a_mac_value: assert property (p_mac_value)
    else $error("accumulator did not take result");

  property p_sat_pos;
    @(posedge clk_sys) disable iff (srst)
    (x_rd && x_lim_use && !long_rd && x_ovf && !x_lim[47]) |=>
      x_operand_bus_out == DDA_POS_MAX;
  endproperty
  a_sat_pos: assert property (p_sat_pos)
    else $error("positive saturation wrong");

  property p_sat_neg;
    @(posedge clk_sys) disable iff (srst)
    (x_rd && x_lim_use && !long_rd && x_ovf && x_lim[47]) |=>
      x_operand_bus_out == DDA_NEG_MAX;
  endproperty
  a_sat_neg: assert property (p_sat_neg)
    else $error("negative saturation wrong");

  property p_err_set;
    @(posedge clk_sys) disable iff (srst)
    err_set |=> limit_err;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("limit error not flagged");

  property p_err_hold;
    @(posedge clk_sys) disable iff (srst)
    (limit_err && !err_clr) |=> limit_err;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("limit error dropped");

  property p_x_write;
    @(posedge clk_sys) disable iff (srst)
    (x_wr && x_wr_sel == DDA_R_X0) |=>
      in_reg[0] == $past(x_operand_bus_in);
  endproperty
  a_x_write: assert property (p_x_write)
    else $error("input register write lost");

  property p_pass;
    @(posedge clk_sys) disable iff (srst)
    (x_rd && x_rd_sel == DDA_R_A1 && scale_mode == DDA_SC_NONE
      && !x_ovf) |=> x_operand_bus_out == $past(acc_reg[0][47:24]);
  endproperty
  a_pass: assert property (p_pass)
    else $error("unscaled read altered");
endmodule

/* File: tb/dda_core_model.sv */
`timescale 1ns/1ns
module dda_core_model
  import dda_pkg::*;
(
  // Clock and unit status
  input wire logic clk_sys,
  input wire logic done,
  input wire logic rd_valid,
  input wire logic [23:0] x_operand_bus_out,
  input wire logic [23:0] y_operand_bus_out,
  // Issue
  output logic op_valid,
  output logic [2:0] op_code,
  output logic op_src_y,
  output logic op_dst_b,
  output logic [1:0] scale_mode,
  // Bus drive
  output logic x_wr,
  output logic [3:0] x_wr_sel,
  output logic [23:0] x_operand_bus_in,
  output logic y_wr,
  output logic [3:0] y_wr_sel,
  output logic [23:0] y_operand_bus_in,
  output logic x_rd,
  output logic [3:0] x_rd_sel,
  output logic y_rd,
  output logic [3:0] y_rd_sel,
  output logic err_clr
);
  initial begin
    {op_valid, op_code, op_src_y, op_dst_b, scale_mode} = '0;
    {x_wr, x_wr_sel, x_operand_bus_in, y_wr, y_wr_sel} = '0;
    {y_operand_bus_in, x_rd, x_rd_sel, y_rd, y_rd_sel, err_clr} = '0;
  end

  // Long writes strobe X only; Y carries the low word
  task automatic wr(input logic y, input logic [3:0] sel,
                    input logic [23:0] d, lo);
    @(posedge clk_sys);
    {x_wr, y_wr} <= {!y, y};
    {x_wr_sel, y_wr_sel} <= {sel, sel};
    x_operand_bus_in <= d;
    y_operand_bus_in <= y ? d : lo;
    @(posedge clk_sys);
    {x_wr, y_wr} <= 2'b00;
    // Released buses change, so stale data cannot pass for a hold
    x_operand_bus_in <= ~d;
    y_operand_bus_in <= ~lo;
  endtask

  task automatic rd(input logic y, input logic [3:0] sel, input logic [1:0] sc,
                    output logic [23:0] xo, yo, output logic v);
    @(posedge clk_sys);
    {x_rd, y_rd} <= {!y, y};
    {x_rd_sel, y_rd_sel} <= {sel, sel};
    scale_mode <= sc;
    @(posedge clk_sys);
    {x_rd, y_rd} <= 2'b00;
    #1;
    {xo, yo, v} = {x_operand_bus_out, y_operand_bus_out, rd_valid};
  endtask

  task automatic clr;
    @(posedge clk_sys);
    err_clr <= 1'b1;
    @(posedge clk_sys);
    err_clr <= 1'b0;
  endtask

  // Poke raises a second request while the unit is busy
  task automatic issue(input logic [2:0] code, input logic sy, db, poke,
                       output int n);
    @(posedge clk_sys);
    {op_valid, op_code, op_src_y, op_dst_b} <= {1'b1, code, sy, db};
    @(posedge clk_sys);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      op_valid <= poke && n == 2;
      if (poke && n == 2) op_code <= DDA_OP_MAC;
      n++;
      #1;
    end while (done !== 1'b1 && n < 40);
  endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench
  import dda_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic op_valid, op_src_y, op_dst_b, x_wr, y_wr, x_rd, y_rd, err_clr;
  logic rd_valid, limit_err, busy, done, v;
  logic [2:0] op_code;
  logic [1:0] scale_mode;
  logic [3:0] x_wr_sel, y_wr_sel, x_rd_sel, y_rd_sel;
  logic [23:0] x_operand_bus_in, y_operand_bus_in, xo, yo;
  logic [23:0] x_operand_bus_out, y_operand_bus_out;
  logic [95:0] dp_product;
  logic signed [95:0] q;
  logic [55:0] acc_m [2];
  logic [23:0] in_m [4];
  logic [31:0] r;
  int fails = 0;
  int checked = 0;
  int seed = 32'h8107eea0;

  always #5 clk_sys = ~clk_sys;

  dda_alu i_dut (.*);
  dda_core_model u_core (.*);

  task chk(input logic [95:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [55:0] f_mul(input logic [23:0] a, b);
    logic signed [47:0] p;
    p = $signed(a) * $signed(b);
    return {{7{p[47]}}, p, 1'b0};
  endfunction

  // Top bit flags a value that saturated; a left shift keeps the old sign
  function automatic logic [48:0] f_lim(input logic [55:0] a,
                                        input logic [1:0] sc);
    logic [56:0] s;
    s = sc == 2'h1 ? {a[55], a[55], a[55:1]} :
        sc == 2'h2 ? {a, 1'b0} : {a[55], a};
    if (s[56:47] == {10{s[47]}}) return {1'b0, s[47:0]};
    return {1'b1, s[56] ? 48'h800000_000000 : 48'h7fffff_ffffff};
  endfunction

  task put(input logic y, input logic [3:0] sel, input logic [23:0] d);
    u_core.wr(y, sel, d, ~d);
    case (sel)
      DDA_R_A0, DDA_R_B0: acc_m[sel == DDA_R_B0][23:0] = d;
      DDA_R_A1, DDA_R_B1: acc_m[sel == DDA_R_B1] = {{8{d[23]}}, d, 24'h0};
      DDA_R_A2, DDA_R_B2: acc_m[sel == DDA_R_B2][55:48] = d[7:0];
      default: in_m[sel[1:0]] = d;
    endcase
  endtask

  task chk_acc(input logic b, input logic [1:0] sc);
    logic [48:0] e;
    e = f_lim(acc_m[b], sc);
    u_core.rd(1'b0, b ? DDA_R_B : DDA_R_A, sc, xo, yo, v);
    chk(v, 1'b1);
    chk({xo, yo}, e[47:0]);
    u_core.rd(1'b1, b ? DDA_R_B1 : DDA_R_A1, sc, xo, yo, v);
    chk(yo, e[47:24]);
    u_core.rd(1'b0, b ? DDA_R_B1 : DDA_R_A1, sc, xo, yo, v);
    chk(xo, e[47:24]);
    @(posedge clk_sys);
    #1;
    chk(limit_err, e[48]);
    if (e[48]) begin
      u_core.clr;
      #1;
      chk(limit_err, 1'b0);
    end
  endtask

  task do_op(input logic [2:0] code, input logic sy, db, poke);
    int n;
    logic [55:0] p;
    p = f_mul(in_m[sy], in_m[2 + sy]);
    u_core.issue(code, sy, db, poke, n);
    chk(n, code == DDA_OP_DPMUL ? DDA_DP_CLKS : 4'(DDA_CLK_PER_ICYC));
    case (code)
      DDA_OP_MAC: acc_m[db] = acc_m[db] + p;
      DDA_OP_MPY: acc_m[db] = p;
      DDA_OP_ADD: acc_m[db] = acc_m[db] + acc_m[!db];
      DDA_OP_SUB: acc_m[db] = acc_m[db] - acc_m[!db];
      default: ;
    endcase
  endtask

  task close_out;
    $display("Mismatches %0d, compares %0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    close_out;
  end

  initial begin
    acc_m = '{default: '0};
    in_m = '{default: '0};
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk({busy, done, rd_valid, limit_err}, 4'h0);
    chk_acc(1'b0, 2'h0);
    chk_acc(1'b1, 2'h0);
    // Halves and extension of one accumulator
    put(1'b0, DDA_R_A1, 24'h800000);
    put(1'b1, DDA_R_A0, 24'h123456);
    u_core.rd(1'b1, DDA_R_A2, 2'h0, xo, yo, v);
    chk(yo, 24'hffffff);
    u_core.rd(1'b0, DDA_R_A0, 2'h0, xo, yo, v);
    chk(xo, 24'h123456);
    put(1'b0, DDA_R_A2, 24'h000001);
    for (int sc = 0; sc < 4; sc++) chk_acc(1'b0, 2'(sc));
    // Long write, X high and Y low
    u_core.wr(1'b0, DDA_R_B, 24'hc00000, 24'h000001);
    acc_m[1] = {8'hff, 24'hc00000, 24'h000001};
    chk_acc(1'b1, 2'h2);
    u_core.rd(1'b1, DDA_R_B2, 2'h0, xo, yo, v);
    chk(yo, 24'hffffff);
    u_core.rd(1'b0, DDA_R_B0, 2'h0, xo, yo, v);
    chk(xo, 24'h000001);
    // Minus one squared does not fit a fraction
    put(1'b0, DDA_R_X0, 24'h800000);
    put(1'b1, DDA_R_Y0, 24'h800000);
    do_op(DDA_OP_MPY, 1'b0, 1'b0, 1'b0);
    chk_acc(1'b0, 2'h0);
    // A no-op leaves its destination as it was
    do_op(DDA_OP_NOP, 1'b0, 1'b1, 1'b0);
    chk_acc(1'b1, 2'h0);
    repeat (40) begin
      r = $random(seed);
      for (int i = 0; i < 4; i++) put(r[i], 4'(i), 24'($random(seed)));
      if (r[10]) put(r[11], r[12] ? DDA_R_B1 : DDA_R_A1, 24'($random(seed)));
      u_core.rd(r[13], 4'(r[15:14]), 2'h0, xo, yo, v);
      chk(r[13] ? yo : xo, in_m[r[15:14]]);
      do_op(3'(1 + r[5:4]), r[6], r[7], 1'b0);
      chk_acc(r[7], r[9:8]);
    end
    // Double precision, with a request dropped while busy
    for (int i = 0; i < 4; i++) put(1'b0, 4'(i), 24'($random(seed)));
    do_op(DDA_OP_DPMUL, 1'b0, 1'b0, 1'b1);
    q = $signed({in_m[1], in_m[0]}) * $signed({in_m[3], in_m[2]});
    chk(dp_product, q << 1);
    chk_acc(1'b0, 2'h0);
    close_out;
  end
endmodule
